/* File: pkg/assc_map.vh */
// register map, field positions and reset values of the sample step control block
`ifndef ASSC_MAP_VH
`define ASSC_MAP_VH
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ASSC_ADDR_W 8
`define ASSC_OFS_STEP_CTL 8'h44
`define ASSC_OFS_INPUT_SEL 8'h40
`define ASSC_OFS_SEQ_CMD 8'hC0
`define ASSC_OFS_SEQ_STAT 8'hC4
`define ASSC_OFS_IRQ_STAT 8'hC8
`define ASSC_OFS_IRQ_MASK 8'hCC
// ----------------------------------------------------------------------------
// step control nibble layout, step n at bits 4n+3..4n
// ----------------------------------------------------------------------------
`define ASSC_BIT_DIFF 0
`define ASSC_BIT_LAST 1
`define ASSC_BIT_IRQEN 2
`define ASSC_BIT_TEMP 3
`define ASSC_STEP_W 4
`define ASSC_SEL_W 2
`define ASSC_SEL_STRIDE 4
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ASSC_RST_STEP_CTL 32'h00000000
`define ASSC_RST_INPUT_SEL 32'h00000000
`define ASSC_RST_IRQ_MASK 32'h00000000
// ----------------------------------------------------------------------------
// command and status bits
// ----------------------------------------------------------------------------
`define ASSC_CMD_START 0
`define ASSC_STAT_BUSY 0
`define ASSC_IRQ_RAW 0
`define ASSC_IRQ_DONE 1
`define ASSC_IRQ_N 2
`endif

/* File: rtl/assc_step_control.v */
// sample step control: per-step settings, step sequencing and interrupt status
//
// Contract
// - temp-select bit converts temperature sensor, else the step's selected pin
// - interrupt-enable bit sets raw interrupt flag at step conversion end
// - raw interrupt reaches interrupt output only while its mask bit is set
// - any number of steps may raise the raw interrupt
// - step with end bit set is final; any position may carry it
// - steps after the first end-marked step are never requested
// - single-step sequencer variant holds first end bit at one always
// - differential-select bit samples the step's inputs differentially
// - differential step with pair index i samples inputs 2i and 2i+1
// - temperature sensor steps are always single-ended
// - 32-bit control: eight nibbles, temp/irq/end/diff, reset zero
// - separate input-select register, first step field at bits 1..0
`timescale 1ns/100ps
`include "assc_map.vh"

module assc_step_control #(
  parameter STEPS = 8,
  parameter SINGLE_STEP = 0,
  parameter CH_W = 3
)(
  input wire clock_in,
  input wire resetn_in,
  input wire [`ASSC_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire write_in,
  input wire read_in,
  output reg [31:0] rdata_out,
  output reg irq_out,
  output reg conv_req_out,
  output reg [CH_W-1:0] conv_channel_out,
  output reg conv_temp_out,
  output reg conv_diff_out,
  output reg [2:0] conv_step_out,
  input wire conv_done_in
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_REQ = 2'b01;
  localparam ST_WAIT = 2'b10;
  // a request pulses two cycles after the start write,
  // and two cycles after each done that is not the last

  reg [31:0] step_ctl;
  reg [31:0] input_sel;
  reg [`ASSC_IRQ_N-1:0] irq_stat;
  reg [`ASSC_IRQ_N-1:0] irq_mask;
  reg [1:0] state;
  reg [2:0] step;

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  reg wr_ctl;
  reg wr_sel;
  reg wr_cmd;
  reg wr_ist;
  reg wr_msk;

  // unmapped offsets fall through and change nothing
  always @*
  begin
    wr_ctl = 1'b0;
    wr_sel = 1'b0;
    wr_cmd = 1'b0;
    wr_ist = 1'b0;
    wr_msk = 1'b0;
    if (write_in)
    begin
      case (addr_in)
        `ASSC_OFS_STEP_CTL: wr_ctl = 1'b1;
        `ASSC_OFS_INPUT_SEL: wr_sel = 1'b1;
        `ASSC_OFS_SEQ_CMD: wr_cmd = 1'b1;
        `ASSC_OFS_IRQ_STAT: wr_ist = 1'b1;
        `ASSC_OFS_IRQ_MASK: wr_msk = 1'b1;
        default: wr_ctl = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // per-step decode
  // --------------------------------------------------------------------------
  wire [STEPS-1:0] step_temp;
  wire [STEPS-1:0] step_irqen;
  wire [STEPS-1:0] step_last;
  wire [STEPS-1:0] step_diff;
  wire [`ASSC_SEL_W-1:0] step_sel [0:STEPS-1];

  genvar g;
  generate
    for (g = 0; g < STEPS; g = g + 1)
    begin : g_step
      assign step_temp[g] = step_ctl[`ASSC_STEP_W*g + `ASSC_BIT_TEMP];
      assign step_irqen[g] = step_ctl[`ASSC_STEP_W*g + `ASSC_BIT_IRQEN];
      // single-step variant: first end bit is wired high
      if (g == 0 && SINGLE_STEP != 0)
      begin : g_fixed
        assign step_last[g] = 1'b1;
      end
      else
      begin : g_free
        assign step_last[g] = step_ctl[`ASSC_STEP_W*g + `ASSC_BIT_LAST];
      end
      assign step_diff[g] = step_ctl[`ASSC_STEP_W*g + `ASSC_BIT_DIFF];
      assign step_sel[g] = input_sel[`ASSC_SEL_STRIDE*g +: `ASSC_SEL_W];
    end
  endgenerate

  // readback image of the control word with the fixed end bit shown
  wire [31:0] ctl_view;
  assign ctl_view = (SINGLE_STEP != 0) ?
    (step_ctl | (32'h00000001 << `ASSC_BIT_LAST)) : step_ctl;

  // --------------------------------------------------------------------------
  // current step view
  // --------------------------------------------------------------------------
  wire cur_last;
  wire cur_temp;
  wire [`ASSC_SEL_W-1:0] cur_sel;
  wire next_diff;

  // the last position always ends a sequence, so a missing end mark cannot hang it
  assign cur_last = step_last[step] || (step == 3'h7);
  assign cur_temp = step_temp[step];
  assign cur_sel = step_sel[step];
  // temperature sensor has no pair, so its diff bit is dropped
  assign next_diff = step_diff[step] && !cur_temp;

  // mux channel: pair index doubled for a differential step
  reg [CH_W-1:0] next_channel;
  always @*
  begin
    if (step_diff[step] && !cur_temp)
      next_channel = {cur_sel[CH_W-2:0], 1'b0};
    else
      next_channel = {{(CH_W-`ASSC_SEL_W){1'b0}}, cur_sel};
  end

  // --------------------------------------------------------------------------
  // registers written by software
  // --------------------------------------------------------------------------
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      step_ctl <= `ASSC_RST_STEP_CTL;
    else if (wr_ctl)
      step_ctl <= wdata_in;
  end

  // only the two select bits of each nibble are kept; the rest read as zero
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      input_sel <= `ASSC_RST_INPUT_SEL;
    else if (wr_sel)
      input_sel <= wdata_in & 32'h33333333;
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_mask <= 2'h0;
    else if (wr_msk)
      irq_mask <= wdata_in[`ASSC_IRQ_N-1:0];
  end

  // --------------------------------------------------------------------------
  // step sequencer
  // --------------------------------------------------------------------------
  wire start_req;
  wire step_done;
  wire raw_event;
  wire seq_event;

  // a start while busy is ignored: only the idle state looks at it
  assign start_req = wr_cmd && wdata_in[`ASSC_CMD_START];
  // a done outside the wait state has no request to answer
  assign step_done = (state == ST_WAIT) && conv_done_in;
  assign raw_event = step_done && step_irqen[step];
  assign seq_event = step_done && cur_last;

  reg [1:0] next_state;
  reg [2:0] next_step;

  always @*
  begin
    next_state = state;
    next_step = step;
    case (state)
      ST_IDLE:
      begin
        next_step = 3'h0;
        // no end mark is needed first: step 7 ends the sequence anyway
        if (start_req)
          next_state = ST_REQ;
      end
      ST_REQ:
      begin
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (conv_done_in)
        begin
          if (cur_last)
          begin
            // nothing beyond the end mark is requested
            next_state = ST_IDLE;
            next_step = 3'h0;
          end
          else
          begin
            next_step = step + 3'h1;
            next_state = ST_REQ;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_step = 3'h0;
      end
    endcase
  end

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= ST_IDLE;
      step <= 3'h0;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
    end
  end

  // --------------------------------------------------------------------------
  // request outputs
  // --------------------------------------------------------------------------
  // qualifiers hold until the next request, so the converter may sample late
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      conv_req_out <= 1'b0;
      conv_channel_out <= {CH_W{1'b0}};
      conv_temp_out <= 1'b0;
      conv_diff_out <= 1'b0;
      conv_step_out <= 3'h0;
    end
    else
    begin
      conv_req_out <= (state == ST_REQ);
      if (state == ST_REQ)
      begin
        conv_channel_out <= next_channel;
        conv_temp_out <= cur_temp;
        conv_diff_out <= next_diff;
        conv_step_out <= step;
      end
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status
  // --------------------------------------------------------------------------
  wire [`ASSC_IRQ_N-1:0] irq_set;
  wire [`ASSC_IRQ_N-1:0] irq_clr;
  wire [`ASSC_IRQ_N-1:0] next_irq_stat;
  assign irq_set = {seq_event, raw_event};
  assign irq_clr = wr_ist ? wdata_in[`ASSC_IRQ_N-1:0] : 2'h0;

  // set beats a clear arriving in the same cycle, so no event is lost
  genvar k;
  generate
    for (k = 0; k < `ASSC_IRQ_N; k = k + 1)
    begin : g_irq
      assign next_irq_stat[k] = irq_set[k] | (irq_stat[k] & ~irq_clr[k]);
    end
  endgenerate

  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_stat <= 2'h0;
    else
      irq_stat <= next_irq_stat;
  end

  // --------------------------------------------------------------------------
  // interrupt output
  // --------------------------------------------------------------------------
  // looks at the next status so the line rises together with the status bit
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(next_irq_stat & irq_mask);
  end

  // --------------------------------------------------------------------------
  // read port, data one cycle after the strobe
  // --------------------------------------------------------------------------
  reg [31:0] next_rdata;

  // unmapped offsets and idle cycles both give zero
  always @*
  begin
    next_rdata = 32'h00000000;
    if (read_in)
    begin
      case (addr_in)
        `ASSC_OFS_STEP_CTL: next_rdata = ctl_view;
        `ASSC_OFS_INPUT_SEL: next_rdata = input_sel;
        `ASSC_OFS_SEQ_STAT: next_rdata = {25'h0, step, 3'h0, state != ST_IDLE};
        `ASSC_OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
        `ASSC_OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // read data stand for one cycle only
  always @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= 32'h00000000;
    else
      rdata_out <= next_rdata;
  end

endmodule

/* File: test/assc_step_monitor.sv */
// port-level assertions for the sample step control block
`timescale 1ns/100ps
`include "assc_map.vh"
module assc_step_monitor (
  input wire clock_in,
  input wire resetn_in,
  input wire [`ASSC_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire write_in,
  input wire read_in,
  input wire [31:0] rdata_out,
  input wire irq_out,
  input wire conv_req_out,
  input wire [2:0] conv_channel_out,
  input wire conv_temp_out,
  input wire conv_diff_out,
  input wire [2:0] conv_step_out,
  input wire conv_done_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // ---------------------------------------------------------------
  // converter link
  // ---------------------------------------------------------------
  temp_no_diff_a:
    assert property (conv_req_out |-> !(conv_temp_out && conv_diff_out)) else $error("temp diff");
  req_pulse_a:
    assert property (conv_req_out |=> !conv_req_out) else $error("req long");
  first_step_a:
    assert property (conv_req_out && !$past(conv_done_in, 2) |-> conv_step_out == 3'h0)
      else $error("first step");
  next_step_a:
    assert property (conv_req_out && conv_step_out != 3'h0 |-> $past(conv_done_in, 2)
      && conv_step_out == $past(conv_step_out) + 3'h1) else $error("step order");
  diff_pair_a:
    assert property (conv_req_out && conv_diff_out |-> !conv_channel_out[0]) else $error("pair");
  hold_step_a:
    assert property (!conv_req_out |-> $stable(conv_step_out) && $stable(conv_channel_out))
      else $error("hold");
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  rdata_idle_a:
    assert property (!$past(read_in) |-> rdata_out == 32'h0) else $error("rdata idle");
  ctl_readback_a:
    assert property (write_in && addr_in == `ASSC_OFS_STEP_CTL ##1 read_in &&
      addr_in == `ASSC_OFS_STEP_CTL |=> rdata_out == $past(wdata_in, 2)) else $error("ctl");
endmodule
bind assc_step_control assc_step_monitor u_mon (.clock_in(clock_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
  .rdata_out(rdata_out), .irq_out(irq_out), .conv_req_out(conv_req_out),
  .conv_channel_out(conv_channel_out), .conv_temp_out(conv_temp_out),
  .conv_diff_out(conv_diff_out), .conv_step_out(conv_step_out), .conv_done_in(conv_done_in));

/* File: test/adc_sample_step_control_bench.sv */
// self-checking testbench for the sample step control block
`timescale 1ns/100ps
`include "assc_map.vh"
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module adc_sample_step_control_bench;
  reg clock_in = 1'b0;
  reg resetn_in = 1'b0;
  reg [7:0] addr_in = 8'h00;
  reg [31:0] wdata_in = 32'h0;
  reg write_in = 1'b0;
  reg read_in = 1'b0;
  reg conv_done_in = 1'b0;
  reg write_s = 1'b0;
  reg read_s = 1'b0;
  reg to_single = 1'b0;
  wire [31:0] rdata_s;
  wire req_s;
  int reqs_s = 0;
  wire [31:0] rdata_out;
  wire irq_out, conv_req_out, conv_temp_out, conv_diff_out;
  wire [2:0] conv_channel_out, conv_step_out;
  int mismatches = 0;
  int checks_done = 0;
  int reqs = 0;
  int base;
  always #25 clock_in = ~clock_in;
  // tally of requests, so trailing steps show up even with no bus traffic
  always @(posedge clock_in) if (conv_req_out === 1'b1) reqs++;
  always @(posedge clock_in) if (req_s === 1'b1) reqs_s++;
  assc_step_control u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .conv_req_out(conv_req_out), .conv_channel_out(conv_channel_out),
    .conv_temp_out(conv_temp_out), .conv_diff_out(conv_diff_out),
    .conv_step_out(conv_step_out), .conv_done_in(conv_done_in));
  // single-step variant on its own strobes, so its fixed end bit is exercised
  assc_step_control #(.SINGLE_STEP(1)) u_dut_single (.clock_in(clock_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_s),
    .read_in(read_s), .rdata_out(rdata_s), .irq_out(), .conv_req_out(req_s),
    .conv_channel_out(), .conv_temp_out(), .conv_diff_out(), .conv_step_out(),
    .conv_done_in(conv_done_in));
  // ---------------------------------------------------------------
  // bus and converter helpers
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    if (to_single) write_s <= 1'b1;
    else write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
    write_s <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clock_in);
    addr_in <= a;
    if (to_single) read_s <= 1'b1;
    else read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    read_s <= 1'b0;
    #1 `CHK("rdata", e, (to_single ? rdata_s : rdata_out))
  endtask
  // write then read with no gap between strobes
  task wrrd(input [7:0] a, input [31:0] d, input [31:0] e);
    @(posedge clock_in); addr_in <= a; wdata_in <= d; write_in <= 1'b1;
    @(posedge clock_in); write_in <= 1'b0; read_in <= 1'b1;
    @(posedge clock_in); read_in <= 1'b0;
    #1 `CHK("readback", e, rdata_out)
  endtask
  task done_pulse;
    @(posedge clock_in); conv_done_in <= 1'b1;
    @(posedge clock_in); conv_done_in <= 1'b0;
  endtask
  task wait_req;
    int i;
    for (i = 0; i < 20 && conv_req_out !== 1'b1; i++) begin @(posedge clock_in); #1; end
    `CHK("req", 1'b1, conv_req_out)
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    rd(`ASSC_OFS_STEP_CTL, 32'h0);
    rd(8'h48, 32'h0);
    wrrd(`ASSC_OFS_STEP_CTL, 32'hFFFFFFFF, 32'hFFFFFFFF);
    wrrd(`ASSC_OFS_INPUT_SEL, 32'hFFFFFFFF, 32'h33333333);
  endtask
  // temp+diff step, diff pair, plain step, then a populated step after the end
  task t_seq;
    wr(`ASSC_OFS_INPUT_SEL, 32'h00000321);
    wr(`ASSC_OFS_STEP_CTL, 32'h0000F61D);
    wr(`ASSC_OFS_IRQ_MASK, 32'h1);
    base = reqs;
    wr(`ASSC_OFS_SEQ_CMD, 32'h1);
    wait_req;
    `CHK("step0", 5'b00010, {conv_step_out, conv_temp_out, conv_diff_out})
    done_pulse;
    wait_req;
    `CHK("step1", 5'b00101, {conv_step_out, conv_temp_out, conv_diff_out})
    `CHK("chan1", 3'h4, conv_channel_out)
    done_pulse;
    wait_req;
    `CHK("step2", 5'b01000, {conv_step_out, conv_temp_out, conv_diff_out})
    `CHK("chan2", 3'h3, conv_channel_out)
    done_pulse;
    repeat (12) @(posedge clock_in);
    #1 `CHK("count", 3, reqs - base)
    `CHK("irq", 1'b1, irq_out)
    rd(`ASSC_OFS_IRQ_STAT, 32'h3);
    wr(`ASSC_OFS_IRQ_STAT, 32'h3);
    rd(`ASSC_OFS_IRQ_STAT, 32'h0);
    `CHK("irq clr", 1'b0, irq_out)
  endtask
  task t_mask;
    wr(`ASSC_OFS_IRQ_MASK, 32'h0);
    wr(`ASSC_OFS_STEP_CTL, 32'h00000006);
    base = reqs;
    wr(`ASSC_OFS_SEQ_CMD, 32'h1);
    wait_req;
    done_pulse;
    repeat (12) @(posedge clock_in);
    #1 `CHK("count", 1, reqs - base)
    `CHK("irq off", 1'b0, irq_out)
    rd(`ASSC_OFS_IRQ_STAT, 32'h3);
    wr(`ASSC_OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clock_in);
    #1 `CHK("irq on", 1'b1, irq_out)
    wr(`ASSC_OFS_IRQ_STAT, 32'h3);
  endtask
  task t_last_step_flag7;
    int i;
    wr(`ASSC_OFS_STEP_CTL, 32'h20000000);
    base = reqs;
    wr(`ASSC_OFS_SEQ_CMD, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      wait_req;
      `CHK("order", i[2:0], conv_step_out)
      done_pulse;
    end
    repeat (12) @(posedge clock_in);
    #1 `CHK("count", 8, reqs - base)
  endtask
  // single-step variant: end bit reads one and stops after one request
  task t_single;
    to_single = 1'b1;
    rd(`ASSC_OFS_STEP_CTL, 32'h2);
    wr(`ASSC_OFS_STEP_CTL, 32'h000000F0);
    rd(`ASSC_OFS_STEP_CTL, 32'hF2);
    base = reqs_s;
    wr(`ASSC_OFS_SEQ_CMD, 32'h1);
    repeat (3) @(posedge clock_in);
    done_pulse;
    repeat (12) @(posedge clock_in);
    #1 `CHK("single count", 1, reqs_s - base)
    to_single = 1'b0;
  endtask
  initial
  begin
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_regs;
    t_seq;
    t_mask;
    t_last_step_flag7;
    t_single;
    final_report;
  end
  initial
  begin
    #100000;
    mismatches++;
    final_report;
  end
endmodule
